// ---- atm_asserts.sv ----
// Checker of bus timing and trip routing at the matrix ports
`timescale 1ns/1ps
module atm_asserts (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire atm_pkg::atm_in_t  det_in,
  input wire atm_pkg::atm_out_t trip_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------------
  // Helpers: detection groups and cable run length (saturates)
  // ---------------------------------------------------------------------
  logic [atm_pkg::CNT_W-1:0] cab_cnt;
  logic                      oth;
  logic                      any_det;
  logic                      ext;
  assign oth = det_in.breaker_zone_sensor | (|det_in.busbar_zone_sensors)
    | det_in.binary_input_one_pulse | det_in.binary_input_two;
  assign any_det = oth | det_in.cable_zone_sensor;
  assign ext = det_in.binary_input_one | det_in.binary_input_one_pulse
    | det_in.binary_input_two;
  // Upper bound of any qualified cable run the design may count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cab_cnt <= '0;
    else if (!det_in.cable_zone_sensor) cab_cnt <= '0;
    else if (~&cab_cnt) cab_cnt <= cab_cnt + 1'b1;
  end
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_ROUTE: assert property (
    trip_out.trip_out_one || trip_out.trip_out_four |-> $past(any_det))
    else $error("trip without detection");
  AST_CBF: assert property (
    trip_out.trip_out_three || trip_out.fast_output_two
    |-> $past(oth) || cab_cnt >= atm_pkg::DELAY_SHORT_CYC)
    else $error("delayed trip too early");
  AST_QUENCH: assert property (
    trip_out.quench_device_command |-> $past(det_in.phase_oc))
    else $error("quench without phase overcurrent");
  AST_FAST_ONE: assert property (
    trip_out.fast_output_one |-> $past(det_in) != '0)
    else $error("fast output one without cause");
  AST_PULSE: assert property (
    trip_out.relay_link_pulse |-> $past(ext))
    else $error("pulse without external overcurrent");
  AST_LINK: assert property (
    trip_out.relay_link_output
    |-> $past(det_in.phase_oc) || $past(det_in.residual_oc))
    else $error("link output without overcurrent");
endmodule : atm_asserts
bind atm_matrix atm_asserts chk_u (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .det_in, .trip_out);

// ---- atm_field_model.sv ----
// Field side model: light sensors and neighbouring relay signals
`timescale 1ns/1ps
module atm_field_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire atm_pkg::atm_in_t want,
  output atm_pkg::atm_in_t      det_in
);
  // Levels launched on the clock so the matrix never sees a race
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) det_in <= '0;
    else det_in <= want;
  end
endmodule : atm_field_model

// ---- atm_matrix.sv ----
// Arc trip routing matrix with APB control, status and interrupt
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - A cable-zone detection at once drives trips one, two and four, qualified.
// - A cable-zone detection lasting past the breaker-fail delay drives trip three and fast output two.
// - A breaker-zone detection at once drives trips one to four and fast output two, qualified.
// - Busbar or external overcurrent detections at once drive trips one, three, four and fast two, trip two after the delay.
// - Qualified outputs need light-only mode or any overcurrent flag active.
// - The quench command follows busbar and external detections under phase overcurrent, plus breaker and pulsed ones in the recommended scheme.
// - In the alarm variant fast output one follows cable, breaker, busbar and second binary input, qualified.
// - In fast position the delayed outputs never assert unless exempted.
// - In the recommended scheme trip two from busbar or external detections always waits for the delay.
// - In the recommended scheme the pulsed link output needs external overcurrent.
// - For cable detections the pulsed link delay is 200 ms, or 300 ms with the select switch on.
// - In the recommended scheme the steady link output follows phase or residual overcurrent only while the pulsed link output is off.
// - In the recommended scheme fast output one follows binary input one and phase or residual overcurrent.
// - Marked outputs fire at once in fast position and wait for the delay otherwise.
// - The delay is 100 ms or 150 ms and the qualified condition must persist throughout.
module atm_matrix (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire atm_pkg::atm_in_t det_in,
  output atm_pkg::atm_out_t    trip_out,
  output logic                 irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Counter step used by every delay timer; restarts when cond drops
  function automatic logic [atm_pkg::CNT_W-1:0] step(
    input logic                      cond,
    input logic [atm_pkg::CNT_W-1:0] cnt,
    input logic [atm_pkg::CNT_W-1:0] lim
  );
    if (!cond) begin
      step = '0;
    end else if (cnt < lim) begin
      step = cnt + 1'b1;
    end else begin
      step = cnt;
    end
  endfunction : step

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [4:0]               ctrl;
  logic [9:0]               irq_status;
  logic [9:0]               irq_enable;
  atm_pkg::atm_scheme_t     scheme;
  logic [atm_pkg::CNT_W-1:0] cnt_cable;
  logic [atm_pkg::CNT_W-1:0] cnt_bus;
  logic [atm_pkg::CNT_W-1:0] cnt_brk;
  logic [atm_pkg::CNT_W-1:0] cnt_pls;
  atm_pkg::atm_out_t        next_out;
  logic [8:0]               prev_out;

  wire logic access = psel && penable;
  wire logic wr     = access && pwrite;
  wire logic fast_sw  = ctrl[atm_pkg::CTRL_FAST];
  wire logic long_sw  = ctrl[atm_pkg::CTRL_LONG];
  wire logic light_only = ctrl[atm_pkg::CTRL_LIGHT];
  wire logic armed    = ctrl[atm_pkg::CTRL_ARM];

  // Control register; scheme latched only while disarmed, so it stays static
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= atm_pkg::CTRL_RST;
    end else if (wr && paddr == atm_pkg::CTRL_OFS) begin
      ctrl <= pwdata[4:0];
    end
  end

  // Scheme held one-hot; changes only when disarmed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scheme <= atm_pkg::SCHEME_RECOMMENDED;
    end else if (!armed) begin
      scheme <= ctrl[atm_pkg::CTRL_SCHEME] ? atm_pkg::SCHEME_ALARM_VARIANT
                                           : atm_pkg::SCHEME_RECOMMENDED;
    end
  end

  // ----------------------------------------------------------------------
  // Detection terms
  // ----------------------------------------------------------------------
  wire logic s1    = det_in.cable_zone_sensor;
  wire logic s2    = det_in.breaker_zone_sensor;
  wire logic sbus  = |det_in.busbar_zone_sensors;
  wire logic ext2  = det_in.binary_input_two;
  wire logic extp  = det_in.binary_input_one_pulse;
  wire logic ext1  = det_in.binary_input_one;
  wire logic i_ph  = det_in.phase_oc;
  wire logic i_res = det_in.residual_oc;
  wire logic rec   = (scheme == atm_pkg::SCHEME_RECOMMENDED);
  wire logic any_oc = i_ph | i_res | ext1 | ext2 | extp;
  wire logic qual   = light_only | any_oc;
  // Pulsed external input counts as a busbar detection only in the recommended scheme
  wire logic busx   = sbus | ext2 | (rec & extp);
  wire logic q_s1   = armed & s1 & qual;
  wire logic q_s2   = armed & s2 & qual;
  wire logic q_bus  = armed & busx & qual;

  // ----------------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------------
  // Qualified condition must persist for the full delay
  wire logic [atm_pkg::CNT_W-1:0] bf_lim = long_sw ?
    atm_pkg::CNT_W'(atm_pkg::DELAY_LONG_CYC) :
    atm_pkg::CNT_W'(atm_pkg::DELAY_SHORT_CYC);
  wire logic [atm_pkg::CNT_W-1:0] pl_lim = long_sw ?
    atm_pkg::CNT_W'(atm_pkg::PULSE_LONG_CYC) :
    atm_pkg::CNT_W'(atm_pkg::PULSE_SHORT_CYC);
  wire logic pls_cond = rec & q_s1 & (ext1 | extp | ext2);
  wire logic brk_pls  = rec & (q_s2 | q_bus) & (ext1 | extp | ext2);

  // Timers restart when their condition falls away early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_cable <= '0;
      cnt_bus   <= '0;
      cnt_brk   <= '0;
      cnt_pls   <= '0;
    end else begin
      cnt_cable <= step(q_s1, cnt_cable, bf_lim);
      cnt_bus   <= step(q_bus, cnt_bus, bf_lim);
      cnt_brk   <= step(brk_pls, cnt_brk, bf_lim);
      cnt_pls   <= step(pls_cond, cnt_pls, pl_lim);
    end
  end

  wire logic cable_dly = (cnt_cable == bf_lim);
  wire logic bus_dly   = (cnt_bus == bf_lim);
  wire logic brk_dly   = (cnt_brk == bf_lim);
  wire logic pls_dly   = (cnt_pls == pl_lim);

  // ----------------------------------------------------------------------
  // Output matrix
  // ----------------------------------------------------------------------
  // Delayed items except the pulsed link are blocked in fast position; trip two is exempt there
  // in the recommended scheme, where it always waits
  always_comb begin
    logic cable_late;
    logic bus_t2;
    logic pulse_any;
    cable_late = cable_dly & ~fast_sw;
    bus_t2     = rec ? bus_dly : (bus_dly & ~fast_sw);
    // Pulsed link: instant in fast position, else timed
    pulse_any  = fast_sw ? (pls_cond | brk_pls)
                         : (pls_dly | brk_dly);
    pulse_any  = pulse_any & rec;
    next_out.trip_out_one   = q_s1 | q_s2 | q_bus;
    next_out.trip_out_two   = q_s1 | q_s2 | bus_t2;
    next_out.trip_out_three = cable_late | q_s2 | q_bus;
    next_out.trip_out_four  = q_s1 | q_s2 | q_bus;
    next_out.fast_output_two = cable_late | q_s2 | q_bus;
    next_out.relay_link_pulse = pulse_any;
    next_out.relay_link_output = rec & armed & (i_ph | i_res)
                                 & ~pulse_any;
    if (rec) begin
      next_out.fast_output_one = armed & (ext1 | i_ph | i_res);
    end else begin
      next_out.fast_output_one = q_s1 | q_s2 | q_bus;
    end
    // Quench needs phase overcurrent; breaker zone only when recommended
    next_out.quench_device_command = armed & i_ph &
      (busx | (rec & s2));
  end

  // Outputs come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_out <= '0;
    end else begin
      trip_out <= next_out;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  // Rising edges of each output plus cable timer expiry outside fast position set sticky bits
  wire logic [9:0] irq_evt = {
    cable_dly & ~fast_sw,
    trip_out & ~atm_pkg::atm_out_t'(prev_out)
  };

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_out <= '0;
    end else begin
      prev_out <= trip_out;
    end
  end

  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status &
        ~((wr && paddr == atm_pkg::IRQ_CL_OFS) ? pwdata[9:0] : 10'h000))
        | irq_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= atm_pkg::IRQ_EN_RST;
    end else if (wr && paddr == atm_pkg::IRQ_EN_OFS) begin
      irq_enable <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------------------------------------
  // APB read side
  // ----------------------------------------------------------------------
  // Two-cycle access with no wait states; pready registered per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          atm_pkg::CTRL_OFS:   prdata <= {27'h0, ctrl};
          atm_pkg::STATUS_OFS: prdata <= {23'h0, trip_out};
          atm_pkg::IRQ_ST_OFS: prdata <= {22'h0, irq_status};
          atm_pkg::IRQ_EN_OFS: prdata <= {22'h0, irq_enable};
          atm_pkg::IRQ_CL_OFS: prdata <= 32'h0000_0000;
          atm_pkg::IN_OFS:     prdata <= {22'h0, det_in};
          atm_pkg::ID_OFS:     prdata <= atm_pkg::ID_VALUE;
          default:             pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : atm_matrix

// ---- atm_pkg.sv ----
// Package of constants and types for the arc trip routing matrix
package atm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned DELAY_SHORT_MS = 100;
  localparam int unsigned DELAY_LONG_MS  = 150;
  localparam int unsigned PULSE_SHORT_MS = 200;
  localparam int unsigned PULSE_LONG_MS  = 300;
  localparam int unsigned DELAY_SHORT_CYC = DELAY_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_LONG_CYC  = DELAY_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_SHORT_CYC = PULSE_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_LONG_CYC  = PULSE_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 23;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_ST_OFS = 12'h008;
  localparam logic [11:0] IRQ_EN_OFS = 12'h00c;
  localparam logic [11:0] IRQ_CL_OFS = 12'h010;
  localparam logic [11:0] IN_OFS     = 12'h014;
  localparam logic [11:0] ID_OFS     = 12'h018;
  // Identification value is arbitrary
  localparam logic [31:0] ID_VALUE   = 32'h0000_a7c1;
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [9:0]  IRQ_EN_RST = 10'h000;

  // Control field positions
  localparam int unsigned CTRL_SCHEME = 0;
  localparam int unsigned CTRL_FAST   = 1;
  localparam int unsigned CTRL_LONG   = 2;
  localparam int unsigned CTRL_LIGHT  = 3;
  localparam int unsigned CTRL_ARM    = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCHEME_ALARM_VARIANT = 2'b01,
    SCHEME_RECOMMENDED   = 2'b10
  } atm_scheme_t;

  typedef struct packed {
    logic       cable_zone_sensor;
    logic       breaker_zone_sensor;
    logic [2:0] busbar_zone_sensors;
    logic       binary_input_one;
    logic       binary_input_one_pulse;
    logic       binary_input_two;
    logic       phase_oc;
    logic       residual_oc;
  } atm_in_t;

  typedef struct packed {
    logic trip_out_one;
    logic trip_out_two;
    logic trip_out_three;
    logic trip_out_four;
    logic relay_link_output;
    logic relay_link_pulse;
    logic fast_output_one;
    logic fast_output_two;
    logic quench_device_command;
  } atm_out_t;

endpackage : atm_pkg

// ---- test_arc_trip_logic_matrix.sv ----
// Self-checking bench for the arc trip routing matrix
`timescale 1ns/1ps
module test_arc_trip_logic_matrix;
  logic              pclk, presetn, psel, penable, pwrite, pready;
  logic              pslverr, irq, err;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd, r;
  atm_pkg::atm_in_t  want, det_in, x;
  atm_pkg::atm_out_t trip_out;
  int                n_errors, comparisons, seed;
  atm_matrix dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .det_in(det_in), .trip_out(trip_out), .irq(irq));
  atm_field_model fld_u (.pclk(pclk), .presetn(presetn), .want(want),
    .det_in(det_in));
  always #25 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // One bus transfer; waits for ready, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Immediate outputs in fast position, link bits included
  function automatic logic [8:0] exp_out(atm_pkg::atm_in_t v, logic al,
                                         logic q);
    atm_pkg::atm_out_t o;
    logic              oth;
    logic              p;
    oth = v.breaker_zone_sensor | (|v.busbar_zone_sensors)
      | v.binary_input_two | (v.binary_input_one_pulse & !al);
    o = '0;
    // Pulsed link fires at once in fast position, needs external overcurrent
    p = !al & q & (v.cable_zone_sensor | oth) & (v.binary_input_one
      | v.binary_input_one_pulse | v.binary_input_two);
    o.relay_link_pulse = p;
    o.relay_link_output = !al & (v.phase_oc | v.residual_oc) & !p;
    o.trip_out_one = (oth | v.cable_zone_sensor) & q;
    o.trip_out_four = o.trip_out_one;
    o.trip_out_two = (v.cable_zone_sensor | v.breaker_zone_sensor) & q;
    o.trip_out_three = oth & q;
    o.fast_output_two = oth & q;
    o.fast_output_one = al ? o.trip_out_one
      : v.binary_input_one | v.phase_oc | v.residual_oc;
    o.quench_device_command = v.phase_oc & (al ? oth
      & (|v.busbar_zone_sensors | v.binary_input_two) : oth);
    return o;
  endfunction : exp_out
  task automatic drive(input atm_pkg::atm_in_t v, input logic al,
                       input logic q);
    want <= v;
    repeat (3) @(posedge pclk);
    check(trip_out, exp_out(v, al, q));
  endtask : drive
  // Scheme changes only while disarmed
  task automatic cfg(input logic [4:0] c);
    apb(1'b1, atm_pkg::CTRL_OFS, {27'h0, c & 5'h0f});
    apb(1'b1, atm_pkg::CTRL_OFS, {27'h0, c});
  endtask : cfg
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    want = '0;
    n_errors = 0;
    comparisons = 0;
    seed = 32'h1f9303bb;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, atm_pkg::ID_OFS, 32'h0);
    check(rd, atm_pkg::ID_VALUE);
    apb(1'b0, atm_pkg::CTRL_OFS, 32'h0);
    check(rd, {27'h0, atm_pkg::CTRL_RST});
    apb(1'b1, 12'hffc, 32'hffff_ffff);
    check({rd[30:0], err}, 32'h1);
    drive(10'h200, 1'b0, 1'b0);
    $display("test registers and disarm done");
    cfg(5'h12);
    drive(10'h100, 1'b0, 1'b0);
    drive(10'h101, 1'b0, 1'b1);
    cfg(5'h1a);
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      drive(r[9:0], 1'b0, 1'b1);
    end
    cfg(5'h1b);
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      x = r[9:0];
      x.binary_input_one_pulse = 1'b0;
      drive(x, 1'b1, 1'b1);
    end
    $display("test fast routing done");
    cfg(5'h18);
    want <= 10'h200;
    repeat (500) @(posedge pclk);
    check(trip_out, 9'h1a0);
    want <= '0;
    repeat (3) @(posedge pclk);
    apb(1'b1, atm_pkg::IRQ_EN_OFS, 32'h0);
    apb(1'b1, atm_pkg::IRQ_CL_OFS, 32'h3ff);
    want <= 10'h200;
    repeat (3) @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b0, atm_pkg::IRQ_ST_OFS, 32'h0);
    check(rd, 32'h1a0);
    apb(1'b0, atm_pkg::STATUS_OFS, 32'h0);
    check(rd, 32'h1a0);
    apb(1'b1, atm_pkg::IRQ_EN_OFS, 32'h100);
    @(posedge pclk);
    check(irq, 1'b1);
    apb(1'b1, atm_pkg::IRQ_CL_OFS, 32'h100);
    @(posedge pclk);
    check(irq, 1'b0);
    $display("test delay and interrupt done");
    end_sim();
  end
endmodule : test_arc_trip_logic_matrix
